// >>> rtl/lrm_core.sv
/*
 * Reservation manager core: APB slave, command interpreter for reserve
 * and release, unit and extent reservation tables and command gating.
 * Assumes firmware loads the command bytes and initiator id, then sets
 * the go bit; reset pins arrive asynchronously from the bus side.
 */
`timescale 1ns/10ps
`default_nettype none
module lrm_core
    import lrm_pkg::*;
#(
    parameter int N_EXT = 8
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Bus reset conditions from the pins
    input wire logic bus_dev_reset,
    input wire logic hard_reset,
    // Interrupt
    output logic irq
);
    localparam int N_LUN = 8;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic [31:0] cdb_lo;
        logic [15:0] cdb_hi;
        logic [3:0] initiator;
        logic ext_en;
        logic go;
        logic [7:0] status;
        logic [3:0] sense;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic [1:0] bdr_sync;
        logic [1:0] hrd_sync;
        lrm_ent_t [N_LUN-1:0] lu;
        lrm_ent_t [N_EXT-1:0] ext;
    } lrm_state_t;

    lrm_state_t s_reg;
    lrm_state_t s_next;

    // Decoded command fields
    logic [7:0] op;
    logic [2:0] lun;
    logic tp;
    logic [2:0] pid;
    logic ext_flag;
    logic [7:0] rid;
    logic [15:0] list_len;
    logic [7:0] byte4;
    logic [3:0] ini;

    assign op = s_reg.cdb_lo[7:0];
    assign lun = s_reg.cdb_lo[8+B1_LUN_LSB +: 3]; // RQ19
    assign tp = s_reg.cdb_lo[8+B1_TP_BIT]; // RQ19
    assign pid = s_reg.cdb_lo[8+B1_PROXY_LSB +: 3]; // RQ19
    assign ext_flag = s_reg.cdb_lo[8+B1_EXT_BIT]; // RQ19
    assign rid = s_reg.cdb_lo[23:16]; // RQ18
    assign list_len = {s_reg.cdb_lo[31:24], s_reg.cdb_hi[7:0]}; // RQ18
    assign byte4 = s_reg.cdb_hi[7:0];
    assign ini = s_reg.initiator;

    // Per-unit occupancy view for the state register
    logic [N_LUN-1:0] lu_busy;
    genvar g;
    generate
        for (g = 0; g < N_LUN; g++) begin : g_lu
            assign lu_busy[g] = s_reg.lu[g].valid;
        end
    endgenerate

    // Next state: bus access, command execution, reset clearing
    always_comb begin
        logic wr;
        logic rd;
        logic foreign;
        logic exempt;
        logic done;
        logic conf;
        logic chk;
        logic slot_hit;
        logic free_hit;
        logic any_reset;
        int hit_idx;
        int free_idx;
        lrm_ent_t cur;
        wr = 1'b0;
        rd = 1'b0;
        foreign = 1'b0;
        exempt = 1'b0;
        done = 1'b0;
        conf = 1'b0;
        chk = 1'b0;
        slot_hit = 1'b0;
        free_hit = 1'b0;
        any_reset = 1'b0;
        hit_idx = 0;
        free_idx = 0;
        cur = s_reg.lu[lun];
        s_next = s_reg;
        s_next.go = 1'b0;

        // Reset pins pass two flip-flops first
        s_next.bdr_sync = {s_reg.bdr_sync[0], bus_dev_reset};
        s_next.hrd_sync = {s_reg.hrd_sync[0], hard_reset};
        any_reset = s_reg.bdr_sync[1] | s_reg.hrd_sync[1];

        // APB: ready in the first access cycle, data prepared at setup
        s_next.pready = psel & ~penable;
        wr = psel & penable & s_reg.pready & pwrite;
        rd = psel & penable & s_reg.pready & ~pwrite;
        // Error flag stands only beside its pready cycle
        s_next.pslverr = 1'b0;
        if (psel && !penable) begin
            s_next.pslverr = 1'b0;
            case (paddr)
                REG_CDB_LO: s_next.prdata = s_reg.cdb_lo;
                REG_CDB_HI: s_next.prdata = {16'h0000, s_reg.cdb_hi};
                REG_CTRL: s_next.prdata = {23'h000000, s_reg.ext_en,
                                           4'h0, s_reg.initiator};
                REG_RESULT: s_next.prdata = {20'h00000, s_reg.sense,
                                             s_reg.status};
                REG_IRQ_STAT: s_next.prdata = {28'h0000000, s_reg.irq_stat};
                REG_IRQ_MASK: s_next.prdata = {28'h0000000, s_reg.irq_mask};
                REG_LU_STATE: s_next.prdata = {24'h000000, lu_busy};
                default: begin
                    s_next.prdata = 32'h00000000;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
        if (wr) begin
            case (paddr)
                REG_CDB_LO: s_next.cdb_lo = pwdata;
                REG_CDB_HI: s_next.cdb_hi = pwdata[15:0];
                REG_CTRL: begin
                    s_next.initiator = pwdata[3:0];
                    s_next.ext_en = pwdata[CTRL_EXT_BIT];
                    s_next.go = pwdata[CTRL_GO_BIT];
                end
                REG_IRQ_MASK: s_next.irq_mask = pwdata[3:0];
                default: ;
            endcase
        end
        // Status read clears; new events below win over the clear
        if (rd && paddr == REG_IRQ_STAT) begin
            s_next.irq_stat = 4'h0;
        end

        // Command execution, one cycle after the go write
        if (s_reg.go) begin
            done = 1'b1;
            s_next.status = ST_GOOD;
            s_next.sense = SK_NONE;
            if (op == OP_RESERVE) begin
                // Unit reserve: ignore id and list length
                if (!ext_flag) begin // RQ16
                    // Foreign unit holder or foreign extent on this unit
                    foreign = cur.valid && cur.owner != ini; // RQ14
                    for (int i = 0; i < N_EXT; i++) begin
                        if (s_reg.ext[i].valid && s_reg.ext[i].lun == lun &&
                            s_reg.ext[i].owner != ini) begin
                            foreign = 1'b1; // RQ14
                        end
                    end
                    if (foreign) begin
                        conf = 1'b1; // RQ14
                    end else begin
                        // Own holder may re-reserve or supersede
                        s_next.lu[lun].valid = 1'b1; // RQ13 RQ15
                        s_next.lu[lun].owner = ini;
                        s_next.lu[lun].third_party_flag = tp;
                        s_next.lu[lun].proxy_device_id = pid;
                        s_next.lu[lun].lun = lun;
                        s_next.lu[lun].res_id = 8'h00;
                    end
                end else if (!s_reg.ext_en) begin
                    chk = 1'b1;
                end else if (list_len != 16'h0000) begin
                    // Extent slot: supersede same id, else take a free one
                    for (int i = N_EXT - 1; i >= 0; i--) begin
                        if (s_reg.ext[i].valid && s_reg.ext[i].lun == lun &&
                            s_reg.ext[i].owner == ini &&
                            s_reg.ext[i].res_id == rid) begin
                            slot_hit = 1'b1;
                            hit_idx = i;
                        end
                        if (!s_reg.ext[i].valid) begin
                            free_hit = 1'b1;
                            free_idx = i;
                        end
                    end
                    if (cur.valid && cur.owner != ini) begin
                        conf = 1'b1;
                    end else if (slot_hit || free_hit) begin
                        if (!slot_hit) begin
                            hit_idx = free_idx;
                        end
                        s_next.ext[hit_idx].valid = 1'b1;
                        s_next.ext[hit_idx].owner = ini;
                        s_next.ext[hit_idx].third_party_flag = tp;
                        s_next.ext[hit_idx].proxy_device_id = pid;
                        s_next.ext[hit_idx].lun = lun;
                        s_next.ext[hit_idx].res_id = rid;
                    end else begin
                        conf = 1'b1;
                    end
                end
            end else if (op == OP_RELEASE) begin // RQ1
                // Extent release shares the reserve option enable
                if (ext_flag && !s_reg.ext_en) begin // RQ7
                    chk = 1'b1; // RQ6
                end else begin
                    // Only own entries whose third-party form matches;
                    // anything else is left alone and answered GOOD
                    if (!ext_flag && cur.valid && cur.owner == ini && // RQ2
                        cur.third_party_flag == tp && // RQ10 RQ9
                        (!tp || cur.proxy_device_id == pid)) begin // RQ11
                        s_next.lu[lun].valid = 1'b0; // RQ4 RQ3
                    end
                    for (int i = 0; i < N_EXT; i++) begin
                        if (s_reg.ext[i].valid && s_reg.ext[i].lun == lun &&
                            s_reg.ext[i].owner == ini && // RQ2
                            s_reg.ext[i].third_party_flag == tp && // RQ10
                            (!tp || // RQ11
                             s_reg.ext[i].proxy_device_id == pid) &&
                            (!ext_flag || // RQ5
                             s_reg.ext[i].res_id == rid)) begin // RQ8
                            s_next.ext[i].valid = 1'b0; // RQ4
                        end
                    end
                    // No mode parameter state is touched here
                end // RQ12
            end else begin
                // Gate ordinary commands against a unit held for another
                exempt = op == OP_INQUIRY || op == OP_REQ_SENSE ||
                         (op == OP_PREVENT && !byte4[0]); // RQ17
                if (cur.valid && !exempt &&
                    (cur.third_party_flag ? {1'b0, cur.proxy_device_id}
                                          : cur.owner) != ini) begin
                    conf = 1'b1; // RQ17
                end
            end
            if (conf) begin
                s_next.status = ST_CONFLICT;
            end
            if (chk) begin
                s_next.status = ST_CHECK;
                s_next.sense = SK_ILLEGAL;
            end
        end

        // Bus device reset or hard reset drops every reservation
        if (any_reset) begin
            for (int i = 0; i < N_LUN; i++) begin
                s_next.lu[i].valid = 1'b0; // RQ13
            end
            for (int i = 0; i < N_EXT; i++) begin
                s_next.ext[i].valid = 1'b0;
            end
        end

        // Sticky event bits
        if (done) begin
            s_next.irq_stat[IRQ_DONE] = 1'b1;
        end
        if (conf) begin
            s_next.irq_stat[IRQ_CONFL] = 1'b1;
        end
        if (chk) begin
            s_next.irq_stat[IRQ_CHECK] = 1'b1;
        end
        if (any_reset) begin
            s_next.irq_stat[IRQ_CLEARED] = 1'b1;
        end
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
            s_reg.ext_en <= CTRL_EXT_RESET;
            s_reg.irq_mask <= IRQ_MASK_RESET;
            s_reg.status <= ST_GOOD;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq = s_reg.irq;
endmodule
`default_nettype wire

// >>> rtl/lrm_pkg.sv
/*
 * Package for the logical-unit reservation manager: register offsets,
 * command byte layout, status codes and the reservation entry types.
 * Assumes a single 200 MHz clock domain and an APB register bus.
 */
// Behaviour
// RQ1 - Release is decoded from operation code 17h in command byte zero.
// RQ2 - Only the initiator that made a reservation may release it.
// RQ3 - Releasing an invalid or foreign reservation returns GOOD, changes nothing.
// RQ4 - Unit release ends all own non-third-party unit and extent reservations.
// RQ5 - Unit release ignores the reservation identification byte.
// RQ6 - Extent release without support ends in CHECK CONDITION, ILLEGAL REQUEST.
// RQ7 - Extent reservation support implies extent release support.
// RQ8 - Extent release ends own reservations with matching identification only.
// RQ9 - Third-party release is always supported.
// RQ10 - Third-party flag clear means an ordinary release.
// RQ11 - Third-party release needs same requester and same proxy device.
// RQ12 - Third-party release leaves proxy device mode parameters untouched.
// RQ13 - Unit reserve grants exclusive use until superseded, released or reset.
// RQ14 - Unit reserve conflicts if unit or any extent is held by another.
// RQ15 - Re-reserving a unit already held by the requester is accepted.
// RQ16 - Unit reserve ignores identification byte and extent list length.
// RQ17 - Other initiators get conflict except inquiry, sense, release, allow.
// RQ18 - Reserve is 16h; identification byte two; list length bytes three-four.
// RQ19 - Byte one: unit 7:5, third party 4, proxy id 3:1, extent 0.
package lrm_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CDB_LO = 8'h00;
    localparam logic [7:0] REG_CDB_HI = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_RESULT = 8'h0c;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_LU_STATE = 8'h18;
    // Control register fields
    localparam int CTRL_GO_BIT = 31;
    localparam int CTRL_EXT_BIT = 8;
    localparam logic CTRL_EXT_RESET = 1'b1;
    // Operation codes
    localparam logic [7:0] OP_RESERVE = 8'h16;
    localparam logic [7:0] OP_RELEASE = 8'h17;
    localparam logic [7:0] OP_INQUIRY = 8'h12;
    localparam logic [7:0] OP_REQ_SENSE = 8'h03;
    localparam logic [7:0] OP_PREVENT = 8'h1e;
    // Byte one field positions
    localparam int B1_LUN_LSB = 5;
    localparam int B1_TP_BIT = 4;
    localparam int B1_PROXY_LSB = 1;
    localparam int B1_EXT_BIT = 0;
    // Status bytes and sense keys
    localparam logic [7:0] ST_GOOD = 8'h00;
    localparam logic [7:0] ST_CHECK = 8'h02;
    localparam logic [7:0] ST_CONFLICT = 8'h18;
    localparam logic [3:0] SK_NONE = 4'h0;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_CONFL = 1;
    localparam int IRQ_CHECK = 2;
    localparam int IRQ_CLEARED = 3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // Reservation entry carried between tables
    typedef struct packed {
        logic valid;
        logic [3:0] owner;
        logic third_party_flag;
        logic [2:0] proxy_device_id;
        logic [2:0] lun;
        logic [7:0] res_id;
    } lrm_ent_t;
endpackage

// >>> tb/lrm_core_sva.sv
/* Port checker for lrm_core: APB timing, command results, interrupt.
   Assumes one clock domain and zero-wait APB answers. */
`timescale 1ns/10ps
`default_nettype none
module lrm_core_chk
    import lrm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and interrupt
    input wire logic bus_dev_reset,
    input wire logic hard_reset,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic acc, rd_res, fresh_reg, ext_reg;
    logic [31:0] cdb_reg;
    logic [3:0] mask_reg;
    assign acc = psel && penable && pready;
    assign rd_res = fresh_reg && acc && !pwrite && paddr == REG_RESULT;
    // Shadow of command bytes, go writes and mask
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cdb_reg <= 32'h0;
            fresh_reg <= 1'b0;
            ext_reg <= 1'b1;
            mask_reg <= 4'h0;
        end else if (acc && pwrite && paddr == REG_CDB_LO) begin
            cdb_reg <= pwdata;
            fresh_reg <= 1'b0;
        end else if (acc && pwrite && paddr == REG_CTRL) begin
            fresh_reg <= pwdata[CTRL_GO_BIT];
            ext_reg <= pwdata[CTRL_EXT_BIT];
        end else if (acc && pwrite && paddr == REG_IRQ_MASK) begin
            mask_reg <= pwdata[3:0];
        end
    end
    chk_rdy_setup: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    chk_rdy_alone: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_slverr_map: assert property (acc && paddr > REG_LU_STATE
        && paddr[1:0] == 2'h0 |-> pslverr)
        else $error("unmapped access without error");
    chk_map_ok: assert property (acc && paddr <= REG_LU_STATE
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped register");
    chk_slverr_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response with data");
    chk_rel_good: assert property (
        rd_res && cdb_reg[7:0] == OP_RELEASE && !(cdb_reg[8] && !ext_reg)
        |-> prdata[7:0] == ST_GOOD)
        else $error("release not answered good");
    chk_ext_check: assert property (
        rd_res && cdb_reg[7:0] == OP_RELEASE && cdb_reg[8] && !ext_reg
        |-> prdata[11:0] == {SK_ILLEGAL, ST_CHECK})
        else $error("extent release without support not refused");
    chk_irq_masked: assert property ((mask_reg == 4'h0) [*3] |-> !irq)
        else $error("irq while fully masked");
    chk_pin_clear: assert property (
        $rose(hard_reset || bus_dev_reset) && mask_reg[3] |-> ##[2:8] irq)
        else $error("reset pin gave no clear event");
    cp_conflict: cover property (acc && !pwrite && paddr == REG_RESULT
        && prdata[7:0] == ST_CONFLICT);
    cp_check: cover property (acc && prdata[7:0] == ST_CHECK);
    cp_pin: cover property ($rose(hard_reset));
endmodule

bind lrm_core lrm_core_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_dev_reset(bus_dev_reset), .hard_reset(hard_reset), .irq(irq));
`default_nettype wire

// >>> tb/lrm_ini_model.sv
/* Initiator model: turns initiator commands into APB traffic.
   Assumes the CDB register packing of lrm_core. */
`timescale 1ns/10ps
`default_nettype none
module lrm_ini_model
    import lrm_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic ext_en = 1'b1;
    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // One transfer, held until pready seen high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Answer taken at the rising edge that sees pready high
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Whole command: bytes, go write, result read
    task automatic cmd(input logic [3:0] ini, input logic [7:0] op,
        input logic [2:0] lun, input logic tp, input logic [2:0] pid,
        input logic x, input logic [7:0] rid, input logic [15:0] len,
        output logic [11:0] res);
        logic [31:0] q;
        logic e;
        xfer(1'b1, REG_CDB_LO, {len[15:8], rid, lun, tp, pid, x, op}, q,
            e);
        xfer(1'b1, REG_CDB_HI, {24'h0, len[7:0]}, q, e);
        xfer(1'b1, REG_CTRL, {1'b1, 22'h0, ext_en, 4'h0, ini}, q, e);
        xfer(1'b0, REG_RESULT, 32'h0, q, e);
        res = q[11:0];
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
/* Testbench for lrm_core: reserve, release, gating, interrupt, pins.
   Assumes the initiator model drives the APB side. */
`timescale 1ns/10ps
`default_nettype none
`define CK(g, e) begin \
    checked++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); \
    end \
end
module tb
    import lrm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n, bus_dev_reset, hard_reset;
    logic psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] r;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    localparam logic [3:0] IA = 4'h1, IB = 4'h2, IC = 4'h3;
    localparam logic N = 1'h0, Y = 1'h1;
    localparam logic [2:0] Z = 3'h0;
    localparam logic [11:0] GD = {SK_NONE, ST_GOOD};
    localparam logic [11:0] CF = {SK_NONE, ST_CONFLICT};
    localparam logic [11:0] IL = {SK_ILLEGAL, ST_CHECK};
    lrm_core #(.N_EXT(8)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_dev_reset(bus_dev_reset),
        .hard_reset(hard_reset), .irq(irq));
    lrm_ini_model ini_u (.ref_clk(ref_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    // Clock
    initial forever #2.5 ref_clk = ~ref_clk;
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic c(input logic [3:0] i, input logic [7:0] op,
        input logic [2:0] lun, input logic tp, input logic [2:0] pid,
        input logic x, input logic [7:0] rid, input logic [15:0] len,
        input logic [11:0] ex);
        ini_u.cmd(i, op, lun, tp, pid, x, rid, len, r);
        `CK(r, ex)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex);
        ini_u.xfer(1'b0, a, 32'h0, q, e);
        `CK(q, ex)
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0;
        bus_dev_reset = 1'b0;
        hard_reset = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(REG_CTRL, 32'h100);
        rd(REG_IRQ_MASK, 32'h0);
        ini_u.xfer(1'b0, 8'h1c, 32'h0, q, e);
        `CK({e, q}, 33'h100000000)
        c(IA, OP_RESERVE, Z, N, Z, N, 8'h55, 16'hffff, GD);
        rd(REG_LU_STATE, 32'h1);
        c(IA, OP_RESERVE, Z, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_RESERVE, Z, N, Z, N, 8'h00, 16'h0, CF);
        c(IB, OP_INQUIRY, Z, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_REQ_SENSE, Z, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_PREVENT, Z, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_PREVENT, Z, N, Z, N, 8'h00, 16'h1, CF);
        c(IB, 8'h08, Z, N, Z, N, 8'h00, 16'h0, CF);
        c(IB, OP_RELEASE, Z, N, Z, N, 8'h55, 16'h0, GD);
        rd(REG_LU_STATE, 32'h1);
        c(IA, OP_RELEASE, Z, N, Z, N, 8'h99, 16'h0, GD);
        rd(REG_LU_STATE, 32'h0);
        // Extents on unit one
        c(IA, OP_RESERVE, 3'h1, N, Z, Y, 8'h07, 16'h8, GD);
        c(IB, OP_RESERVE, 3'h1, N, Z, N, 8'h00, 16'h0, CF);
        c(IA, OP_RELEASE, 3'h1, N, Z, Y, 8'h09, 16'h0, GD);
        c(IB, OP_RESERVE, 3'h1, N, Z, N, 8'h00, 16'h0, CF);
        c(IA, OP_RELEASE, 3'h1, N, Z, Y, 8'h07, 16'h0, GD);
        c(IA, OP_RESERVE, 3'h1, N, Z, Y, 8'h03, 16'h8, GD);
        c(IA, OP_RELEASE, 3'h1, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_RESERVE, 3'h1, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_RELEASE, 3'h1, N, Z, N, 8'h00, 16'h0, GD);
        ini_u.ext_en = 1'b0;
        c(IA, OP_RELEASE, 3'h1, N, Z, Y, 8'h07, 16'h0, IL);
        c(IA, OP_RESERVE, 3'h1, N, Z, Y, 8'h07, 16'h8, IL);
        ini_u.ext_en = 1'b1;
        // Third-party reservation on unit two for device five
        c(IA, OP_RESERVE, 3'h2, Y, 3'h5, N, 8'h00, 16'h0, GD);
        c(IA, OP_RELEASE, 3'h2, N, Z, N, 8'h00, 16'h0, GD);
        rd(REG_LU_STATE, 32'h4);
        c(IA, OP_RELEASE, 3'h2, Y, 3'h4, N, 8'h00, 16'h0, GD);
        c(IC, OP_RELEASE, 3'h2, Y, 3'h5, N, 8'h00, 16'h0, GD);
        rd(REG_LU_STATE, 32'h4);
        c(IA, OP_RELEASE, 3'h2, Y, 3'h5, N, 8'h00, 16'h0, GD);
        rd(REG_LU_STATE, 32'h0);
        // Interrupt: masked, unmasked, read-clear
        ini_u.xfer(1'b0, REG_IRQ_STAT, 32'h0, q, e);
        c(IA, OP_RESERVE, Z, N, Z, N, 8'h00, 16'h0, GD);
        c(IB, OP_RESERVE, Z, N, Z, N, 8'h00, 16'h0, CF);
        @(negedge ref_clk);
        `CK(irq, 1'b0)
        ini_u.xfer(1'b1, REG_IRQ_MASK, 32'h2, q, e);
        repeat (3) @(negedge ref_clk);
        `CK(irq, 1'b1)
        ini_u.xfer(1'b0, REG_IRQ_STAT, 32'h0, q, e);
        `CK(q[IRQ_CONFL], 1'b1)
        repeat (3) @(negedge ref_clk);
        `CK(irq, 1'b0)
        // Both reset pins clear reservations
        ini_u.xfer(1'b1, REG_IRQ_MASK, 32'h8, q, e);
        for (int k = 0; k < 2; k++) begin
            c(IA, OP_RESERVE, 3'h3, N, Z, N, 8'h00, 16'h0, GD);
            @(posedge ref_clk);
            hard_reset <= (k == 0);
            bus_dev_reset <= (k == 1);
            repeat (2) @(posedge ref_clk);
            hard_reset <= 1'b0;
            bus_dev_reset <= 1'b0;
            repeat (8) @(negedge ref_clk);
            `CK(irq, 1'b1)
            rd(REG_LU_STATE, 32'h0);
            ini_u.xfer(1'b0, REG_IRQ_STAT, 32'h0, q, e);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
